// >>> core/acr_config.sv
`timescale 1ns/1ps
// How it works
// - one twelve-bit configuration word, serially written
// - word kept through all power-down states
// - clock may pause after eight bits
// - readback only in one-shot mode
// - bit 11 picks internal reference
// - bit 10 picks two's complement
// - bit 9 picks 12 or 24 sample clocks
// - bit 8 halves the conversion clock
// - bit 7 picks pseudo-differential inputs
// - bits 6:5 pick conversion mode
// - bits 4:3 pick sweep order
// - sweep order ignored outside sweep modes
// - bit 2 picks status pin function
// - bits 1:0 set fifo trigger level
// - sampling starts after select command nibble
// - write command is 1010 plus data
// - read gives four blanks then word
// - frame sync high selects rising capture
module acr_config (
    input wire logic CLK_I,
    input wire logic SYS_RST_I,
    input wire acr_pkg::acr_link_t LINK_I,
    input wire logic PWR_DOWN_I,
    output logic SDO_O,
    output logic SDO_OE_O,
    output acr_pkg::acr_cfg_t CFG_O,
    output logic [11:0] CFG_WORD_O,
    output logic SAMPLE_START_O,
    output logic SAMPLING_O,
    output logic CONV_TICK_O
);
    import acr_pkg::*;

    // decode of nibbles that start a sampling period
    function automatic logic is_select(input logic [3:0] cmd);
        is_select = (cmd <= CMD_CH_LAST) ||
                    (cmd >= CMD_TEST_FIRST && cmd <= CMD_TEST_LAST);
    endfunction : is_select

    logic [11:0] cfg_reg; // stored configuration word
    logic sclk_reg; // previous serial clock level
    logic cs_n_reg; // previous chip select level
    logic fs_reg; // previous frame sync level
    logic rise_mode_reg; // capture on rising edge when set
    logic active_reg; // frame in progress
    logic [4:0] bit_cnt_reg; // bits captured this frame
    logic [15:0] shift_reg; // incoming bits
    logic read_ok_reg; // this frame reads the word back
    logic [11:0] out_reg; // outgoing word bits
    logic sdo_reg; // serial output flip-flop
    logic sampling_reg; // sampling window open
    logic [4:0] samp_cnt_reg; // edges left in sampling window
    logic start_reg; // one-cycle sampling start
    logic div_reg; // conversion clock divider phase
    logic tick_reg; // conversion clock tick

    logic sclk_rise; // serial clock rising this cycle
    logic sclk_fall; // serial clock falling this cycle
    logic cap_edge; // edge that captures input
    logic launch_edge; // edge that changes output
    logic cs_fall; // chip select going active
    logic fs_fall; // frame sync falling
    logic [15:0] shift_next; // shift register with new bit
    logic [4:0] bit_cnt_next; // count after this capture
    logic take_bit; // capture happening this cycle

    // edge detection on the serial pins
    assign sclk_rise = LINK_I.sclk & ~sclk_reg;
    assign sclk_fall = ~LINK_I.sclk & sclk_reg;
    assign cs_fall = ~LINK_I.cs_n & cs_n_reg;
    assign fs_fall = ~LINK_I.frame_sync_in & fs_reg;
    assign cap_edge = rise_mode_reg ? sclk_rise : sclk_fall;
    assign launch_edge = rise_mode_reg ? sclk_fall : sclk_rise;
    // a deselected chip ignores an edge that lands on the same cycle
    assign take_bit = active_reg && !LINK_I.cs_n && cap_edge &&
                      bit_cnt_reg < 5'(FRAME_BITS);
    assign shift_next = {shift_reg[14:0], LINK_I.sdi};
    assign bit_cnt_next = bit_cnt_reg + 5'd1;

    // pin history
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            sclk_reg <= 1'b0;
            cs_n_reg <= 1'b1;
            fs_reg <= 1'b0;
        end else begin
            sclk_reg <= LINK_I.sclk;
            cs_n_reg <= LINK_I.cs_n;
            fs_reg <= LINK_I.frame_sync_in;
        end
    end

    // frame start, edge polarity and bit counting
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            rise_mode_reg <= 1'b1;
            active_reg <= 1'b0;
            bit_cnt_reg <= 5'd0;
            shift_reg <= 16'h0000;
        end else if (LINK_I.cs_n) begin
            // chip select idle ends any frame
            active_reg <= 1'b0;
            bit_cnt_reg <= 5'd0;
        end else if (cs_fall && LINK_I.frame_sync_in) begin
            // frame sync high at select: spi style, rising capture
            rise_mode_reg <= 1'b1;
            active_reg <= 1'b1;
            bit_cnt_reg <= 5'd0;
        end else if (fs_fall) begin
            // frame sync falling starts a dsp style frame
            rise_mode_reg <= 1'b0;
            active_reg <= 1'b1;
            bit_cnt_reg <= 5'd0;
        end else if (take_bit) begin
            // a stopped clock simply waits here, so a pause is harmless
            shift_reg <= shift_next;
            bit_cnt_reg <= bit_cnt_next;
        end
    end

    // configuration word update
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            cfg_reg <= CFG_RESET;
        end else if (take_bit && bit_cnt_next == 5'(FRAME_BITS) &&
                     shift_reg[14:11] == CMD_WRITE_CFG) begin
            // commit only on the last bit of a write cycle
            cfg_reg <= shift_next[11:0];
        end
        // power-down has no path into this register
    end

    // readback: blank nibble then the word, msb first
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            read_ok_reg <= 1'b0;
            out_reg <= 12'h000;
            sdo_reg <= 1'b0;
        end else if (!active_reg || fs_fall) begin
            // a new dsp frame under a held select must not inherit the last read
            read_ok_reg <= 1'b0;
            sdo_reg <= 1'b0;
        end else begin
            if (take_bit && bit_cnt_next == 5'(CMD_BITS)) begin
                // read allowed only in one-shot mode
                read_ok_reg <= shift_next[3:0] == CMD_READ_CFG &&
                               cfg_reg[POS_MODE+:2] == MODE_ONE_SHOT;
                out_reg <= cfg_reg;
            end
            if (launch_edge && read_ok_reg && bit_cnt_reg >= 5'(CMD_BITS)) begin
                sdo_reg <= out_reg[11];
                out_reg <= {out_reg[10:0], 1'b0};
            end
        end
    end

    // sampling window after a select command
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            sampling_reg <= 1'b0;
            samp_cnt_reg <= 5'd0;
            start_reg <= 1'b0;
        end else begin
            start_reg <= 1'b0;
            // a new select restarts the window and wins over the countdown
            if (take_bit && bit_cnt_next == 5'(CMD_BITS) && is_select(shift_next[3:0])) begin
                start_reg <= 1'b1;
                sampling_reg <= 1'b1;
                samp_cnt_reg <= cfg_reg[POS_SLEN] ? 5'(SAMPLE_LONG) :
                                5'(SAMPLE_SHORT);
            end else if (sampling_reg && cap_edge) begin
                samp_cnt_reg <= samp_cnt_reg - 5'd1;
                if (samp_cnt_reg == 5'd1) begin
                    sampling_reg <= 1'b0;
                end
            end
        end
    end

    // conversion clock ticks from the serial clock
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            div_reg <= 1'b0;
            tick_reg <= 1'b0;
        end else begin
            tick_reg <= 1'b0;
            if (sclk_rise && !PWR_DOWN_I) begin
                div_reg <= ~div_reg;
                tick_reg <= ~cfg_reg[POS_CDIV] | div_reg;
            end
        end
    end

    // field decode
    always_comb begin
        CFG_O.ref_internal = cfg_reg[POS_REF];
        CFG_O.twos_complement = cfg_reg[POS_FMT];
        CFG_O.long_sample = cfg_reg[POS_SLEN];
        CFG_O.clk_div2 = cfg_reg[POS_CDIV];
        CFG_O.pseudo_diff = cfg_reg[POS_DIFF];
        CFG_O.mode = acr_mode_t'(cfg_reg[POS_MODE+:2]);
        CFG_O.sweep_active = cfg_reg[POS_MODE+1];
        // order forced to zero outside the sweep modes
        CFG_O.sweep_order = cfg_reg[POS_MODE+1] ? cfg_reg[POS_SWEEP+:2] :
                            2'b00;
        CFG_O.pin_is_busy_flag = cfg_reg[POS_PINF];
        unique case (cfg_reg[POS_TRIG+:2])
            2'b00: CFG_O.trigger_level = TRIG_FULL;
            2'b01: CFG_O.trigger_level = TRIG_3Q;
            2'b10: CFG_O.trigger_level = TRIG_HALF;
            2'b11: CFG_O.trigger_level = TRIG_1Q;
        endcase
    end

    // outputs
    assign CFG_WORD_O = cfg_reg;
    assign SDO_O = sdo_reg;
    assign SDO_OE_O = active_reg && read_ok_reg;
    assign SAMPLE_START_O = start_reg;
    assign SAMPLING_O = sampling_reg;
    assign CONV_TICK_O = tick_reg;

    // checks
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (SYS_RST_I);

    a_write_commit: assert property (take_bit && bit_cnt_next == 5'(FRAME_BITS) &&
        shift_reg[14:11] == CMD_WRITE_CFG |=> cfg_reg == $past(shift_next[11:0]))
        else $error("write cycle did not commit word");
    a_word_stable: assert property (!(take_bit && bit_cnt_next == 5'(FRAME_BITS) &&
        shift_reg[14:11] == CMD_WRITE_CFG) |=> $stable(cfg_reg))
        else $error("word changed outside a write");
    a_pdown_keep: assert property (PWR_DOWN_I |=> $stable(cfg_reg) ||
        $past(take_bit))
        else $error("word lost during power down");
    a_read_mode: assert property (read_ok_reg |->
        cfg_reg[POS_MODE+:2] == 2'b00)
        else $error("readback outside one-shot mode");
    a_sample_start: assert property (start_reg |-> sampling_reg &&
        is_select(shift_reg[3:0]) && bit_cnt_reg == 5'(CMD_BITS))
        else $error("sampling start without select command");
    a_sample_len: assert property ($rose(sampling_reg) |->
        samp_cnt_reg == (cfg_reg[POS_SLEN] ? 5'(SAMPLE_LONG) : 5'(SAMPLE_SHORT)))
        else $error("wrong sampling length");
    a_sweep_mask: assert property (!cfg_reg[6] |->
        CFG_O.sweep_order == 2'b00)
        else $error("sweep order leaks outside sweep modes");
    a_trig_level: assert property (cfg_reg[1:0] == 2'b11 |->
        CFG_O.trigger_level == TRIG_1Q)
        else $error("wrong trigger level");
    a_rise_mode: assert property (cs_fall && LINK_I.frame_sync_in &&
        !LINK_I.cs_n |=> rise_mode_reg && active_reg && bit_cnt_reg == 5'd0)
        else $error("spi frame not set to rising capture");
    a_div_tick: assert property (tick_reg && cfg_reg[POS_CDIV]
        |-> ##1 !tick_reg)
        else $error("divided tick too fast");

    // framing and readback guards
    a_abort_idle: assert property (LINK_I.cs_n |=>
        !active_reg && !SDO_OE_O)
        else $error("frame still open after deselect");
    a_abort_keep: assert property (active_reg && LINK_I.cs_n |=>
        $stable(cfg_reg))
        else $error("word changed by an aborted frame");
    a_oe_window: assert property (SDO_OE_O |->
        bit_cnt_reg >= 5'(CMD_BITS))
        else $error("output enabled before the blank nibble ended");
    a_read_refuse: assert property (take_bit && bit_cnt_next == 5'(CMD_BITS) &&
        shift_next[3:0] == CMD_READ_CFG && cfg_reg[POS_MODE+:2] != 2'b00 |=> !SDO_OE_O)
        else $error("readback enabled outside one-shot mode");

    // sampling guards
    a_start_pulse: assert property (start_reg |=>
        !start_reg)
        else $error("sampling start longer than one cycle");
    a_no_start: assert property (take_bit && bit_cnt_next == 5'(CMD_BITS) &&
        !is_select(shift_next[3:0]) |=> !start_reg)
        else $error("sampling started by a non-select command");
    a_sample_end: assert property (sampling_reg && cap_edge &&
        samp_cnt_reg == 5'h01 && !(take_bit && bit_cnt_next == 5'(CMD_BITS)) |=> !sampling_reg)
        else $error("sampling window overran its length");

    // conversion clock, decode and capture edge guards
    a_pdown_tick: assert property (PWR_DOWN_I |=>
        !tick_reg)
        else $error("conversion tick during power down");
    a_tick_full: assert property (sclk_rise && !PWR_DOWN_I &&
        !cfg_reg[POS_CDIV] |=> tick_reg)
        else $error("undivided conversion clock missed a tick");
    a_sweep_pass: assert property (cfg_reg[POS_MODE+1] |->
        CFG_O.sweep_order == cfg_reg[POS_SWEEP+:2])
        else $error("sweep order lost in sweep modes");
    a_spi_hold: assert property (rise_mode_reg && active_reg && sclk_fall &&
        !fs_fall && !LINK_I.cs_n |=> $stable(bit_cnt_reg))
        else $error("rising-capture frame counted a falling edge");

    c_write_cycle: cover property (take_bit && bit_cnt_next == 5'(FRAME_BITS) &&
        shift_reg[14:11] == CMD_WRITE_CFG);
    c_read_cycle: cover property (read_ok_reg && launch_edge);
    c_long_sample: cover property ($fell(sampling_reg) && cfg_reg[POS_SLEN]);
    c_dsp_frame: cover property (fs_fall && !LINK_I.cs_n);
    c_short_sample: cover property ($fell(sampling_reg) && !cfg_reg[POS_SLEN]);
endmodule : acr_config

// >>> core/acr_pkg.sv
package acr_pkg;
    // configuration word width and its reset value
    localparam int unsigned CFG_W = 12;
    localparam logic [11:0] CFG_RESET = 12'h000;
    // frame geometry in serial bits
    localparam int unsigned FRAME_BITS = 16;
    localparam int unsigned CMD_BITS = 4;
    localparam int unsigned PAUSE_BIT = 8;
    // sampling length in serial clock edges
    localparam int unsigned SAMPLE_SHORT = 12;
    localparam int unsigned SAMPLE_LONG = 24;
    // field positions inside the configuration word
    localparam int unsigned POS_REF = 11;
    localparam int unsigned POS_FMT = 10;
    localparam int unsigned POS_SLEN = 9;
    localparam int unsigned POS_CDIV = 8;
    localparam int unsigned POS_DIFF = 7;
    localparam int unsigned POS_MODE = 5;
    localparam int unsigned POS_SWEEP = 3;
    localparam int unsigned POS_PINF = 2;
    localparam int unsigned POS_TRIG = 0;
    // command nibble codes
    localparam logic [3:0] CMD_CH_LAST = 4'h7;
    localparam logic [3:0] CMD_READ_CFG = 4'h9;
    localparam logic [3:0] CMD_WRITE_CFG = 4'hA;
    localparam logic [3:0] CMD_TEST_FIRST = 4'hB;
    localparam logic [3:0] CMD_TEST_LAST = 4'hD;
    // fifo trigger level in words for each code
    localparam logic [3:0] TRIG_FULL = 4'h8;
    localparam logic [3:0] TRIG_3Q = 4'h6;
    localparam logic [3:0] TRIG_HALF = 4'h4;
    localparam logic [3:0] TRIG_1Q = 4'h2;

    // conversion modes
    typedef enum logic [1:0] {
        MODE_ONE_SHOT = 2'b00,
        MODE_REPEAT = 2'b01,
        MODE_SWEEP = 2'b10,
        MODE_REPEAT_SWEEP = 2'b11
    } acr_mode_t;

    // decoded configuration carried to the converter
    typedef struct packed {
        logic ref_internal;
        logic twos_complement;
        logic long_sample;
        logic clk_div2;
        logic pseudo_diff;
        acr_mode_t mode;
        logic sweep_active;
        logic [1:0] sweep_order;
        logic pin_is_busy_flag;
        logic [3:0] trigger_level;
    } acr_cfg_t;

    // serial link pins seen by the device
    typedef struct packed {
        logic cs_n;
        logic frame_sync_in;
        logic sclk;
        logic sdi;
    } acr_link_t;
endpackage : acr_pkg

// >>> test/acr_host_model.sv
`timescale 1ns/1ps
// host serial port: spi style frames, plus a dsp style write frame
module acr_host_model (
    input wire logic CLK_I,
    input wire logic SDO_I,
    input wire logic SDO_OE_I,
    input wire logic SAMPLING_I,
    output acr_pkg::acr_link_t LINK_O
);
    import acr_pkg::*;
    logic [15:0] rd_bits; // sdo bits taken at each sclk rise
    logic oe_seen; // output enable seen during the frame
    int samp_cnt; // capture edges met while sampling is open
    // idle pins: deselected, clock stands low
    initial begin
        LINK_O = '{cs_n: 1'b1, frame_sync_in: 1'b1, sclk: 1'b0, sdi: 1'b0};
    end
    // three system clocks per sclk level keeps each level at least two cycles
    task automatic half();
        repeat (3) @(negedge CLK_I);
    endtask : half
    // one frame sent msb first; a short frame ends by raising chip select
    task automatic frame(input logic [31:0] data, input int nbits, input bit pause);
        rd_bits = '0;
        oe_seen = 1'b0;
        samp_cnt = 0;
        @(negedge CLK_I);
        LINK_O.cs_n = 1'b0;
        half();
        for (int i = 0; i < nbits; i++) begin
            LINK_O.sdi = data[nbits - 1 - i];
            half();
            if (SAMPLING_I === 1'b1) samp_cnt++;
            // a disabled output reads as ones, so a late enable shows up
            rd_bits = {rd_bits[14:0], (SDO_OE_I === 1'b1) ? SDO_I : 1'b1};
            oe_seen = oe_seen | (SDO_OE_I === 1'b1);
            LINK_O.sclk = 1'b1;
            half();
            LINK_O.sclk = 1'b0;
            if (pause && i == 7) repeat (20) @(negedge CLK_I);
        end
        half();
        LINK_O.cs_n = 1'b1;
        // released data line must not keep showing the last bit
        LINK_O.sdi = ~LINK_O.sdi;
        half();
    endtask : frame
    // dsp style frame: frame sync falls under a held select, capture on sclk fall
    task automatic dsp_frame(input logic [15:0] data);
        @(negedge CLK_I);
        LINK_O.cs_n = 1'b0;
        half();
        LINK_O.frame_sync_in = 1'b0;
        half();
        LINK_O.frame_sync_in = 1'b1;
        for (int i = 0; i < 16; i++) begin
            // wrong level while the clock rises, so a rising capture is caught
            LINK_O.sdi = ~data[15 - i];
            LINK_O.sclk = 1'b1;
            half();
            LINK_O.sdi = data[15 - i];
            half();
            LINK_O.sclk = 1'b0;
            half();
        end
        LINK_O.cs_n = 1'b1;
        LINK_O.sdi = ~LINK_O.sdi;
        half();
    endtask : dsp_frame
endmodule : acr_host_model

// >>> test/acr_config_bench.sv
`timescale 1ns/1ps
module acr_config_bench;
    import acr_pkg::*;
    logic CLK_I = 1'b0; // system clock
    logic SYS_RST_I = 1'b1; // reset held at start
    logic PWR_DOWN_I = 1'b0; // power-down level
    acr_link_t link; // serial pins from the host
    logic sdo, sdo_oe, sample_start, sampling, conv_tick;
    acr_cfg_t cfg; // decoded fields
    logic [11:0] cfg_word; // raw word
    int num_errors = 0;
    int comparisons = 0;
    int ticks = 0; // conversion ticks seen
    int starts = 0; // sampling starts seen
    logic [11:0] words [4] = '{12'h01E, 12'h36D, 12'hC50, 12'h0A3};
    logic [3:0] cmds [7] = '{4'h0, 4'h7, 4'hB, 4'hD, 4'h8, 4'hE, 4'hF};
    // 25 MHz clock
    always #20 CLK_I = ~CLK_I;
    // pulse counters
    always @(posedge CLK_I) begin
        if (conv_tick === 1'b1) ticks++;
        if (sample_start === 1'b1) starts++;
    end
    acr_host_model host (.CLK_I(CLK_I), .SDO_I(sdo), .SDO_OE_I(sdo_oe),
        .SAMPLING_I(sampling), .LINK_O(link));
    acr_config DUT (.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .LINK_I(link),
        .PWR_DOWN_I(PWR_DOWN_I), .SDO_O(sdo), .SDO_OE_O(sdo_oe), .CFG_O(cfg),
        .CFG_WORD_O(cfg_word), .SAMPLE_START_O(sample_start), .SAMPLING_O(sampling),
        .CONV_TICK_O(conv_tick));
    // compare and count
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // expected decode of a word
    function automatic acr_cfg_t exp_cfg(input logic [11:0] w);
        acr_cfg_t e;
        e = '0;
        {e.ref_internal, e.twos_complement, e.long_sample, e.clk_div2} = w[11:8];
        e.pseudo_diff = w[7];
        e.mode = acr_mode_t'(w[6:5]);
        e.sweep_active = w[6];
        e.sweep_order = w[6] ? w[4:3] : 2'b00;
        e.pin_is_busy_flag = w[2];
        case (w[1:0])
            2'b00: e.trigger_level = 4'h8;
            2'b01: e.trigger_level = 4'h6;
            2'b10: e.trigger_level = 4'h4;
            default: e.trigger_level = 4'h2;
        endcase
        return e;
    endfunction : exp_cfg
    // verdict
    task automatic complete_run();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : complete_run
    // full write then field check
    task automatic write_cfg(input logic [11:0] w, input bit pause);
        host.frame({16'h0000, CMD_WRITE_CFG, w}, 16, pause);
        check("word", 16'(cfg_word), 16'(w));
        check("fields", 16'(cfg), 16'(exp_cfg(w)));
    endtask : write_cfg
    // main sequence
    initial begin
        repeat (10) @(negedge CLK_I);
        SYS_RST_I = 1'b0;
        check("reset word", 16'(cfg_word), 16'(CFG_RESET));
        write_cfg(12'h000, 1'b0);
        foreach (words[k]) write_cfg(words[k], k[0]);
        // read refused outside one-shot mode
        host.frame({16'h0000, CMD_READ_CFG, 12'h000}, 16, 1'b0);
        check("refused oe", 16'(host.oe_seen), 16'h0000);
        check("kept after read", 16'(cfg_word), 16'h00A3);
        // aborted write of fifteen bits
        host.frame({17'h0, CMD_WRITE_CFG, 11'h7FF}, 15, 1'b0);
        check("short write", 16'(cfg_word), 16'h00A3);
        write_cfg(12'h21E, 1'b1);
        host.frame({16'h0000, CMD_READ_CFG, 12'h000}, 16, 1'b0);
        check("readback", {4'h0, host.rd_bits[11:0]}, 16'h021E);
        check("read oe", 16'(host.oe_seen), 16'h0001);
        check("oe released", 16'(sdo_oe), 16'h0000);
        starts = 0;
        host.frame({4'h3, 28'h0}, 32, 1'b0);
        check("long start", 16'(starts), 16'h0001);
        check("long len", 16'(host.samp_cnt), 16'(SAMPLE_LONG));
        write_cfg(12'h000, 1'b0);
        foreach (cmds[k]) begin
            ticks = 0;
            starts = 0;
            host.frame({16'h0000, cmds[k], 12'hFFF}, 16, 1'b0);
            check("start", 16'(starts), 16'(k < 4));
            check("short len", 16'(host.samp_cnt), 16'(k < 4 ? SAMPLE_SHORT : 0));
            check("ticks", 16'(ticks), 16'h0010);
            check("kept", 16'(cfg_word), 16'h0000);
        end
        write_cfg(12'h100, 1'b0);
        ticks = 0;
        host.frame({16'h0000, 4'h1, 12'h000}, 16, 1'b0);
        check("half ticks", 16'(ticks), 16'h0008);
        PWR_DOWN_I = 1'b1;
        ticks = 0;
        host.frame({16'h0000, 4'h8, 12'h000}, 16, 1'b0);
        host.frame({16'h0000, 4'h2, 12'h000}, 16, 1'b0);
        check("down ticks", 16'(ticks), 16'h0000);
        check("down word", 16'(cfg_word), 16'h0100);
        PWR_DOWN_I = 1'b0;
        // dsp style write with falling capture
        host.dsp_frame({CMD_WRITE_CFG, 12'h0C5});
        check("dsp word", 16'(cfg_word), 16'h00C5);
        // second reset in mid-run
        SYS_RST_I = 1'b1;
        repeat (2) @(negedge CLK_I);
        SYS_RST_I = 1'b0;
        @(negedge CLK_I);
        check("second reset", 16'(cfg_word), 16'(CFG_RESET));
        complete_run();
    end
endmodule : acr_config_bench
